//--- ring_osc_pkg.sv
/*
  Constants, field layouts and carrier types for the ring oscillator
  phase, status, sample and countdown register block.
  Assumes an APB slave with 32-bit data and byte addresses.
*/
package ring_osc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_PHASE = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_SAMPLE = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h20;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned PH_KEY_LSB = 4;
  localparam int unsigned PH_KEY_MSB = 11;
  localparam int unsigned PH_EN_BIT = 3;
  localparam int unsigned PH_FLIP_BIT = 2;
  localparam int unsigned PH_SHIFT_LSB = 0;
  localparam int unsigned PH_SHIFT_MSB = 1;
  localparam logic [7:0] PH_KEY_OK = 8'hAA;
  localparam logic [7:0] PH_KEY_RST = 8'h00;
  localparam logic PH_EN_RST = 1'b1;
  localparam logic PH_FLIP_RST = 1'b0;
  localparam logic [1:0] PH_SHIFT_RST = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned ST_STABLE_BIT = 31;
  localparam int unsigned ST_BAD_BIT = 24;
  localparam int unsigned ST_DIVRUN_BIT = 16;
  localparam int unsigned ST_ENABLED_BIT = 12;
  localparam int unsigned SAMPLE_BIT = 0;
  localparam logic SAMPLE_RST = 1'b1;
  localparam logic STATUS_RST = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned DIV_CODE_W = 12;
  localparam int unsigned DIV_VAL_W = 6;
  localparam int unsigned DIV_FIELD_W = 5;
  localparam logic [DIV_CODE_W-1:0] DIV_KEY = 12'hAA0;
  localparam logic [DIV_VAL_W-1:0] DIV_MAX = 6'h1F;
  localparam logic [DIV_VAL_W-1:0] DIV_ZERO_VAL = 6'h20;
  localparam logic [DIV_VAL_W-1:0] DIV_ONE = 6'h01;
  localparam int unsigned SHIFT_DEPTH = 4;

  typedef struct packed {
    logic [7:0] key;
    logic en;
    logic flip;
    logic [1:0] shift;
  } ring_osc_phase_t;

  typedef struct packed {
    logic stable;
    logic enabled;
    logic div_running;
    logic sample;
  } ring_osc_osc_t;

endpackage

//--- ring_osc_sync.sv
/*
  Two flip-flop level synchroniser, one per bit, with a per-bit reset value.
  Assumes the inputs change slowly compared with the sampling clock.
*/
`timescale 1ns/1ns
module ring_osc_sync
  import ring_osc_pkg::*;
#(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

//--- ring_osc_edge.sv
/*
  Rising edge detector on an already synchronised level.
  Assumes the level comes from logic on the same clock.
*/
`timescale 1ns/1ns
module ring_osc_edge
  import ring_osc_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic level_i,
  output logic rise_o
);

  logic last_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_q <= RST_VAL;
    end
    else
    begin
      last_q <= level_i;
    end
  end

  assign rise_o = level_i & ~last_q;

endmodule

//--- ring_osc_phase_ctrl.sv
/*
  Phase output control, status, oscillator sample and countdown registers
  behind an APB slave, plus the divided and phase-shifted output.
  Assumes the ring oscillator and its status lines are asynchronous to
  pclk and run well below half the pclk rate, so every oscillator edge
  is seen after synchronisation. Divider codes and illegal writes to the
  neighbouring settings arrive from logic on pclk.
*/
// Implementation choice: register access over APB.
`timescale 1ns/1ns
module ring_osc_phase_ctrl
  import ring_osc_pkg::*;
#(
  parameter int unsigned CNT_W = 8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ring_osc_i,
  input wire logic osc_stable_i,
  input wire logic osc_enabled_i,
  input wire logic div_running_i,
  input wire logic [DIV_CODE_W-1:0] div_code_i,
  input wire logic illegal_write_ext_i,
  output logic div_clk_o,
  output logic phase_clk_o,
  output logic [DIV_VAL_W-1:0] div_value_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.

  generate
    if (CNT_W < 1 || CNT_W > DATA_W)
    begin : g_bad_cnt
      $error("CNT_W must lie between 1 and the data width.");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  ring_osc_phase_t phase_q;
  ring_osc_phase_t phase_wr;
  ring_osc_phase_t phase_eff;
  ring_osc_osc_t osc_raw;
  ring_osc_osc_t osc_sync;
  logic illegal_write_flag_q;
  logic [CNT_W-1:0] count_q;
  logic [DIV_VAL_W-1:0] div_val;
  logic [DIV_VAL_W-1:0] div_half;
  logic [DIV_VAL_W-1:0] div_cnt_q;
  logic div_one;
  logic div_raw_q;
  logic [SHIFT_DEPTH-1:0] hist_q;
  logic shift_tap;
  logic osc_rise;
  logic setup_ph;
  logic wr_acc;
  logic hit_phase;
  logic hit_status;
  logic hit_sample;
  logic hit_count;
  logic hit_any;
  logic [DATA_W-1:0] rd_d;
  logic [DATA_W-1:0] prdata_q;
  logic slverr_q;
  logic phase_bad_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator domain inputs.

  assign osc_raw.stable = osc_stable_i;
  assign osc_raw.enabled = osc_enabled_i;
  assign osc_raw.div_running = div_running_i;
  assign osc_raw.sample = ring_osc_i;

  ring_osc_sync #(
    .WIDTH($bits(ring_osc_osc_t)),
    .RST_VAL({STATUS_RST, STATUS_RST, STATUS_RST, SAMPLE_RST})
  ) u_osc_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_i(osc_raw),
    .sync_o(osc_sync)
  );

  ring_osc_edge #(
    .RST_VAL(SAMPLE_RST)
  ) u_osc_edge (
    .pclk(pclk),
    .presetn(presetn),
    .level_i(osc_sync.sample),
    .rise_o(osc_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode. Zero wait states; unmapped addresses answer with an error.

  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & ~pslverr;

  always_comb
  begin
    hit_phase = 1'b0;
    hit_status = 1'b0;
    hit_sample = 1'b0;
    hit_count = 1'b0;
    if (paddr == OFF_PHASE)
    begin
      hit_phase = 1'b1;
    end
    else if (paddr == OFF_STATUS)
    begin
      hit_status = 1'b1;
    end
    else if (paddr == OFF_SAMPLE)
    begin
      hit_sample = 1'b1;
    end
    else if (paddr == OFF_COUNT)
    begin
      hit_count = 1'b1;
    end
  end

  assign hit_any = hit_phase | hit_status | hit_sample | hit_count;

  ////////////////////////////////////////////////////////////////////////////
  // Phase control register.

  assign phase_wr.key = pwdata[PH_KEY_MSB:PH_KEY_LSB];
  assign phase_wr.en = pwdata[PH_EN_BIT];
  assign phase_wr.flip = pwdata[PH_FLIP_BIT];
  assign phase_wr.shift = pwdata[PH_SHIFT_MSB:PH_SHIFT_LSB];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_q.key <= PH_KEY_RST;
      phase_q.en <= PH_EN_RST;
      phase_q.flip <= PH_FLIP_RST;
      phase_q.shift <= PH_SHIFT_RST;
    end
    else if (wr_acc && hit_phase)
    begin
      phase_q <= phase_wr;
    end
  end

  always_comb
  begin
    phase_eff = phase_q;
    if (phase_q.key != PH_KEY_OK)
    begin
      phase_eff.en = 1'b1;
      phase_eff.flip = PH_FLIP_RST;
      phase_eff.shift = PH_SHIFT_RST;
    end
  end

  assign phase_bad_wr = wr_acc & hit_phase & (phase_wr.key != PH_KEY_OK);

  ////////////////////////////////////////////////////////////////////////////
  // Illegal write flag. A new event in the clearing cycle keeps it set.

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      illegal_write_flag_q <= STATUS_RST;
    end
    else if (phase_bad_wr || illegal_write_ext_i)
    begin
      illegal_write_flag_q <= 1'b1;
    end
    else if (wr_acc && hit_status)
    begin
      illegal_write_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Countdown. A bus write wins over a decrement in the same cycle.

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_q <= '0;
    end
    else if (wr_acc && hit_count)
    begin
      count_q <= pwdata[CNT_W-1:0];
    end
    else if (osc_rise && (count_q != '0))
    begin
      count_q <= count_q - CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output divider decode.

  always_comb
  begin
    div_val = DIV_MAX;
    if (div_code_i[DIV_CODE_W-1:DIV_FIELD_W] == DIV_KEY[DIV_CODE_W-1:DIV_FIELD_W])
    begin
      if (div_code_i[DIV_FIELD_W-1:0] == '0)
      begin
        div_val = DIV_ZERO_VAL;
      end
      else
      begin
        div_val = {1'b0, div_code_i[DIV_FIELD_W-1:0]};
      end
    end
  end

  assign div_one = (div_val == DIV_ONE);
  assign div_half = div_val >> 1;

  // Odd ratios from three up give a duty cycle below one half; divide by one passes the sample through.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt_q <= '0;
    end
    else if (osc_rise)
    begin
      if (div_cnt_q >= div_val - DIV_ONE)
      begin
        div_cnt_q <= '0;
      end
      else
      begin
        div_cnt_q <= div_cnt_q + DIV_ONE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_raw_q <= 1'b0;
    end
    else if (div_one)
    begin
      div_raw_q <= osc_sync.sample;
    end
    else
    begin
      div_raw_q <= (div_cnt_q < div_half);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase shift by whole oscillator periods.

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hist_q <= '0;
    end
    else if (osc_rise)
    begin
      hist_q <= {hist_q[SHIFT_DEPTH-2:0], div_raw_q};
    end
  end

  always_comb
  begin
    shift_tap = div_raw_q;
    if (!div_one && phase_eff.shift != PH_SHIFT_RST)
    begin
      shift_tap = hist_q[phase_eff.shift - 2'h1];
    end
  end

  // Shift changes take effect at once, so a glitch may show on the output.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_clk_o <= 1'b0;
      div_clk_o <= 1'b0;
    end
    else
    begin
      div_clk_o <= div_raw_q;
      if (!phase_eff.en)
      begin
        phase_clk_o <= 1'b0;
      end
      else
      begin
        phase_clk_o <= shift_tap ^ (phase_eff.flip & ~div_one);
      end
    end
  end

  assign div_value_o = div_val;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup cycle and held through the access.

  always_comb
  begin
    rd_d = '0;
    if (hit_phase)
    begin
      rd_d[PH_KEY_MSB:PH_KEY_LSB] = phase_q.key;
      rd_d[PH_EN_BIT] = phase_q.en;
      rd_d[PH_FLIP_BIT] = phase_q.flip;
      rd_d[PH_SHIFT_MSB:PH_SHIFT_LSB] = phase_q.shift;
    end
    else if (hit_status)
    begin
      rd_d[ST_STABLE_BIT] = osc_sync.stable;
      rd_d[ST_BAD_BIT] = illegal_write_flag_q;
      rd_d[ST_DIVRUN_BIT] = osc_sync.div_running;
      rd_d[ST_ENABLED_BIT] = osc_sync.enabled;
    end
    else if (hit_sample)
    begin
      rd_d[SAMPLE_BIT] = osc_sync.sample;
    end
    else if (hit_count)
    begin
      rd_d[CNT_W-1:0] = count_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= '0;
      slverr_q <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_q <= rd_d;
      slverr_q <= ~hit_any;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & slverr_q;

endmodule

//--- ring_osc_props.sv
/* Concurrent checks on the bus answers and the divider decode.
   Assumes a single pclk domain; bound to ring_osc_phase_ctrl below. */
`timescale 1ns/1ns
module ring_osc_props
  import ring_osc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ring_osc_i,
  input wire logic osc_stable_i,
  input wire logic osc_enabled_i,
  input wire logic div_running_i,
  input wire logic [DIV_CODE_W-1:0] div_code_i,
  input wire logic illegal_write_ext_i,
  input wire logic div_clk_o,
  input wire logic phase_clk_o,
  input wire logic [DIV_VAL_W-1:0] div_value_o
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic rd_acc;
  logic mapped;
  logic in_rng;
  assign rd_acc = psel && penable && !pwrite;
  assign mapped = paddr inside {OFF_PHASE, OFF_STATUS, OFF_SAMPLE, OFF_COUNT};
  assign in_rng = div_code_i >= 12'hAA0 && div_code_i <= 12'hABF;
  ////////////////////////////////////////
  // Four quiet cycles outlast the two-stage synchroniser.
  sequence stable_low_s;
    !osc_stable_i [*4];
  endsequence
  sequence status_setup_s;
    psel && !penable && !pwrite && paddr == OFF_STATUS;
  endsequence
  AST_UNMAPPED: assert property (psel && penable && !mapped |-> pslverr && prdata == '0)
    else $error("unmapped access not refused");
  AST_MAPPED_OK: assert property (psel && penable && mapped |-> !pslverr)
    else $error("mapped access refused");
  AST_PHASE_RSV: assert property (rd_acc && paddr == OFF_PHASE |-> prdata[31:12] == '0)
    else $error("phase reserved bits set");
  AST_STATUS_RSV: assert property (rd_acc && paddr == OFF_STATUS |-> (prdata & 32'h7EFE_EFFF) == '0)
    else $error("status reserved bits set");
  AST_SAMPLE_RSV: assert property (rd_acc && paddr == OFF_SAMPLE |-> prdata[31:1] == '0)
    else $error("sample reserved bits set");
  AST_COUNT_RSV: assert property (rd_acc && paddr == OFF_COUNT |-> prdata[31:8] == '0)
    else $error("count reserved bits set");
  AST_STABLE_LOW: assert property (stable_low_s ##0 status_setup_s |=> !prdata[31])
    else $error("stable bit high while input low");
  AST_DIV_ZERO: assert property (div_code_i == 12'hAA0 |-> div_value_o == 6'h20)
    else $error("divide by zero code not 32");
  AST_DIV_OTHER: assert property (!in_rng |-> div_value_o == 6'h1F)
    else $error("bad divider code not 31");
  AST_DIV_MID: assert property (in_rng && div_code_i[4:0] != 5'h0 |-> div_value_o == {1'b0, div_code_i[4:0]})
    else $error("divider value wrong");
  AST_READY: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  AST_BAD_SET: assert property (illegal_write_ext_i ##1 status_setup_s |=> prdata[ST_BAD_BIT])
    else $error("illegal write flag not shown");
endmodule
bind ring_osc_phase_ctrl ring_osc_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ring_osc_i(ring_osc_i), .osc_stable_i(osc_stable_i),
  .osc_enabled_i(osc_enabled_i), .div_running_i(div_running_i), .div_code_i(div_code_i),
  .illegal_write_ext_i(illegal_write_ext_i), .div_clk_o(div_clk_o),
  .phase_clk_o(phase_clk_o), .div_value_o(div_value_o));

//--- ring_osc_phase_status_counter_tb_top.sv
/* Self-checking bench for the phase, status, sample and countdown block.
   Assumes zero-wait APB and an oscillator far slower than pclk. */
`timescale 1ns/1ns
module ring_osc_phase_status_counter_tb_top
  import ring_osc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 0, penable = 0, pwrite = 0, ring_osc_i = 1, osc_stable_i = 0;
  logic osc_enabled_i = 0, div_running_i = 0, illegal_write_ext_i = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DIV_CODE_W-1:0] div_code_i = 12'hAA0;
  logic [DATA_W-1:0] prdata, rd;
  logic pready, pslverr, div_clk_o, phase_clk_o, err;
  logic [DIV_VAL_W-1:0] div_value_o;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  int flag_m, cnt_m, n, k, m;
  logic dv, ph_en = 1'b0;
  always #20 pclk = ~pclk;
  ring_osc_phase_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ring_osc_i(ring_osc_i), .osc_stable_i(osc_stable_i),
    .osc_enabled_i(osc_enabled_i), .div_running_i(div_running_i), .div_code_i(div_code_i),
    .illegal_write_ext_i(illegal_write_ext_i), .div_clk_o(div_clk_o),
    .phase_clk_o(phase_clk_o), .div_value_o(div_value_o));
  ////////////////////////////////////////
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // The request stays put until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    apb(1'b0, a, '0);
    chk(rd, exp);
  endtask
  // Eight pclk per oscillator period keeps it well under half the bus rate.
  task automatic pulses(input int p);
    repeat (p)
    begin
      ring_osc_i <= 1'b1;
      repeat (4) @(posedge pclk);
      ring_osc_i <= 1'b0;
      repeat (4) @(posedge pclk);
      if (!ph_en)
        chk({31'h0, phase_clk_o}, 32'h0);
      if (cnt_m > 0)
        cnt_m--;
    end
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h9EA1));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rdchk(OFF_PHASE, 32'h8);
    rdchk(OFF_STATUS, 32'h0);
    rdchk(OFF_SAMPLE, 32'h1);
    rdchk(OFF_COUNT, 32'h0);
    for (k = 0; k < 6; k++)
    begin
      n = $urandom;
      if (k % 2 == 0)
        n[11:4] = 8'hAA;
      flag_m = (n[11:4] != 8'hAA);
      apb(1'b1, OFF_PHASE, n);
      rdchk(OFF_PHASE, n & 32'hFFF);
      rdchk(OFF_STATUS, flag_m << 24);
      apb(1'b1, OFF_STATUS, $urandom);
      rdchk(OFF_STATUS, 32'h0);
    end
    illegal_write_ext_i <= 1'b1;
    @(posedge pclk);
    illegal_write_ext_i <= 1'b0;
    rdchk(OFF_STATUS, 32'h0100_0000);
    for (k = 0; k < 8; k++)
    begin
      {osc_stable_i, osc_enabled_i, div_running_i} <= 3'(k);
      repeat (3) @(posedge pclk);
      rdchk(OFF_STATUS, {k[2], 7'h1, 7'h0, k[0], 3'h0, k[1], 12'h0});
    end
    ring_osc_i <= 1'b0;
    repeat (3) @(posedge pclk);
    rdchk(OFF_SAMPLE, 32'h0);
    apb(1'b1, OFF_SAMPLE, 32'hFFFF_FFFF);
    rdchk(OFF_SAMPLE, 32'h0);
    apb(1'b1, 8'h40, $urandom);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h24, '0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, OFF_PHASE, 32'hAA0);
    for (k = 0; k < 4; k++)
    begin
      cnt_m = 3 + $urandom % 8;
      apb(1'b1, OFF_COUNT, ($urandom & 32'hFFFF_FF00) | cnt_m);
      pulses(k * 4);
      repeat (4) @(posedge pclk);
      rdchk(OFF_COUNT, cnt_m);
    end
    apb(1'b1, OFF_PHASE, 32'hAA8);
    for (k = 0; k < 48; k++)
    begin
      div_code_i <= 12'hA98 + 12'(k);
      @(posedge pclk);
      n = k - 8;
      chk(div_value_o, (n < 0 || n > 31) ? 31 : (n == 0 ? 32 : n));
    end
    // Divide by one with flip set, divide by two with random flip and shift, then a bad key.
    // Four warm-up periods refill the shift history before any output is judged.
    ph_en = 1'b1;
    for (k = 0; k < 10; k++)
    begin
      n = $urandom;
      n[2] = n[2] | (k < 4);
      if (k < 4)
        n[1:0] = 2'h0;
      flag_m = (k >= 4 && k < 8) ? (n[2] ^ n[0]) : 0;
      div_code_i <= (k < 4) ? 12'hAA1 : 12'hAA2;
      apb(1'b1, OFF_PHASE, {20'h0, (k < 8) ? 8'hAA : 8'h55, k < 8, n[2:0]});
      pulses(4);
      for (m = 0; m < 4; m++)
      begin
        dv = div_clk_o;
        pulses(1);
        chk({31'h0, phase_clk_o}, {31'h0, div_clk_o ^ flag_m[0]});
        if (k >= 4)
          chk({31'h0, div_clk_o}, {31'h0, ~dv});
      end
    end
    report_and_stop();
  end
endmodule
